/* inc/fcct_pkg.sv */
// Constants and types shared by the four-channel counter/timer design.
// Assumes a single system clock; the CPU bus signals are synchronous to it.
// Overview of operation
// - A written word with bit 0 set is the addressed channel's control word.
// - Control bit 2 set makes the next word to that channel its time constant.
// - A bit-0-clear word to channel zero is the interrupt vector, not control.
// - The two channel select inputs pick channel 0 to 3 in binary.
// - Hardware reset stops counts, clears enables, idles outputs, floats data bus.
// - Control bit 1 stops the channel, still updates fields; new constant needed.
// - Bits 1 and 2 together halt the channel until the new constant arrives.
// - Control bit 7 enables the zero-count interrupt in both modes, any time.
// - Bit 6 picks timer or counter; bit 5 picks prescale 16 or 256 in timer mode.
// - Bit 4 picks trigger edge; changing it while running acts as an edge.
// - Auto-triggered timer starts after a fixed delay and reloads at zero.
// - Externally triggered timer waits, then starts on the active trigger edge.
// - Time constant 1 to 256, with zero meaning 256.
// - Timer interval equals clock period times prescale times time constant.
// - Vector bits 2 and 1 carry the requesting channel; channel 0 wins.
// - With chip select, writes take words and reads return the down-counter.
// - Trigger edges decrement in counter mode and start the timer in timer mode.
// - Priority out is high only with priority in high and no channel in service.
// - Open-drain interrupt output is low while priority in is high and an enabled channel with a pending zero count has none at or above it in service.
// - Write is request and select with read high; read needs all three low.
// - Request with opcode fetch is acknowledge; winning channel drives its vector.
// - Return opcodes ED then 4D release the channel in service.
// - Channels 0 to 2 give a high zero-count pulse; channel 3 has none.
// - Reading a channel never disturbs the running count.
// - A new constant during counting takes effect at the next zero.

package fcct_pkg;

  localparam int NUM_CH = 4;

  // Control word field positions.
  localparam int BIT_CTRL    = 0;
  localparam int BIT_SWRST   = 1;
  localparam int BIT_TCF     = 2;
  localparam int BIT_EXTTRIG = 3;
  localparam int BIT_RISING  = 4;
  localparam int BIT_PSC256  = 5;
  localparam int BIT_COUNTER = 6;
  localparam int BIT_IE      = 7;

  // Vector base occupies bits 7..3.
  localparam int VEC_LSB = 3;

  // Prescaler terminal values, divide by 16 or 256.
  localparam logic [7:0] PSC_LIM_16  = 8'h0F;
  localparam logic [7:0] PSC_LIM_256 = 8'hFF;

  // Return-from-interrupt opcode bytes.
  localparam logic [7:0] RETURN_OP_FIRST  = 8'hED;
  localparam logic [7:0] RETURN_OP_SECOND = 8'h4D;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TC_RST   = 8'h00;
  localparam logic [4:0] VEC_RST  = 5'h00;

  // Clocks from the time-constant write until the auto-triggered timer starts running.
  localparam logic [1:0] START_DELAY_CYC = 2'h3;

  typedef enum logic [1:0] {
    FCCT_IDLE,
    FCCT_DELAY,
    FCCT_ARMED,
    FCCT_RUN
  } fcct_ch_state_t;

endpackage : fcct_pkg

/* inc/fcct_trig_if.sv */
// Carries the filtered trigger levels from the synchroniser to the channels.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps

interface fcct_trig_if;
  logic [3:0] level;

  modport src (output level);
  modport dst (input  level);
endinterface : fcct_trig_if

/* core/fcct_trig_sync.sv */
// Three-stage synchroniser with agreement filter for the trigger inputs.
// Assumes the trigger pins are asynchronous to clk.
`timescale 1ns/1ps

module fcct_trig_sync (
  // Clock and reset
  input  logic       clk,
  input  logic       nrst,
  // Trigger pins
  input  logic [3:0] ext_clock_trigger,
  // Filtered levels
  fcct_trig_if.src   trig
);

  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] level_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end
    else
    begin
      s1_q <= ext_clock_trigger;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A level change counts only once the second and third stages agree.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      level_q <= 4'h0;
    else
      level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
  end

  assign trig.level = level_q;

endmodule : fcct_trig_sync

/* core/fcct_top.sv */
// Four-channel counter/timer with CPU I/O port and daisy-chain interrupts.
// Assumes the CPU bus strobes are synchronous to clk; trigger pins are not.
`timescale 1ns/1ps

module fcct_top (
  // Clock and reset
  input  logic       clk,
  input  logic       nrst,
  // CPU bus control
  input  logic       chip_enable_n,
  input  logic       io_request_n,
  input  logic       read_n,
  input  logic       opcode_fetch_cycle_n,
  input  logic [1:0] channel_select,
  // Data bus, split into three signals
  input  logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic       data_oe_n,
  // Daisy chain and interrupt request (open drain)
  input  logic       priority_in,
  output logic       priority_out,
  output logic       int_req_out,
  output logic       int_req_oe_n,
  // Channel pins
  input  logic [3:0] ext_clock_trigger,
  output logic [2:0] zero_count_pulse
);

  localparam int NCH = fcct_pkg::NUM_CH;

  fcct_trig_if trig_bus ();

  fcct_trig_sync u_sync (
    .clk               (clk),
    .nrst              (nrst),
    .ext_clock_trigger (ext_clock_trigger),
    .trig              (trig_bus.src)
  );

  // Bus cycle decode.
  logic       wr_cond;
  logic       rd_cond;
  logic       ack_cond;
  logic       fetch_cond;
  logic       wr_prev_q;
  logic       ack_prev_q;
  logic       fetch_prev_q;
  logic       wr_stb;
  logic       ack_stb;
  logic       fetch_end;

  // Channel state.
  logic [7:0]                  ctrl_q  [NCH];
  logic [7:0]                  tc_q    [NCH];
  logic [7:0]                  cnt_q   [NCH];
  logic [7:0]                  psc_q   [NCH];
  logic [1:0]                  dly_q   [NCH];
  fcct_pkg::fcct_ch_state_t    st_q    [NCH];
  logic                        tcf_q   [NCH];
  logic                        pend_q  [NCH];
  logic                        srv_q   [NCH];
  logic                        lvl_p_q [NCH];
  logic                        zero_ev [NCH];

  // Interrupt and vector state.
  logic [4:0] vec_q;
  logic       win_v;
  logic [1:0] win;
  logic       rel_v;
  logic [1:0] rel;
  logic       grant;
  logic       release_stb;
  logic       any_srv;
  logic       int_q;
  logic       ack_drive_q;
  logic [7:0] data_q;
  logic [7:0] op_q;
  logic       after_ed_q;

  assign wr_cond    = !io_request_n && !chip_enable_n && read_n && opcode_fetch_cycle_n;
  assign rd_cond    = !io_request_n && !chip_enable_n && !read_n && opcode_fetch_cycle_n;
  assign ack_cond   = !io_request_n && !opcode_fetch_cycle_n;
  assign fetch_cond = io_request_n && !opcode_fetch_cycle_n && !read_n;
  assign wr_stb     = wr_cond && !wr_prev_q;
  assign ack_stb    = ack_cond && !ack_prev_q;
  assign fetch_end  = fetch_prev_q && !fetch_cond;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_prev_q    <= 1'b0;
      ack_prev_q   <= 1'b0;
      fetch_prev_q <= 1'b0;
    end
    else
    begin
      wr_prev_q    <= wr_cond;
      ack_prev_q   <= ack_cond;
      fetch_prev_q <= fetch_cond;
    end
  end

  // Vector base: a word with bit 0 clear to channel zero when no constant is due.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      vec_q <= fcct_pkg::VEC_RST;
    else if (wr_stb && channel_select == 2'h0 && !data_in[fcct_pkg::BIT_CTRL] && !tcf_q[0])
      vec_q <= data_in[7:fcct_pkg::VEC_LSB];
  end

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic       wr_i;
    logic       ctl_wr;
    logic       tc_wr;
    logic       timer;
    logic       edge_i;
    logic       slope_chg;
    logic       trig_ev;
    logic       tick;
    logic       dec;
    logic [7:0] psc_lim;

    assign wr_i      = wr_stb && (channel_select == 2'(i));
    assign tc_wr     = wr_i && tcf_q[i];
    assign ctl_wr    = wr_i && !tcf_q[i] && data_in[fcct_pkg::BIT_CTRL];
    assign timer     = !ctrl_q[i][fcct_pkg::BIT_COUNTER];
    assign psc_lim   = ctrl_q[i][fcct_pkg::BIT_PSC256] ? fcct_pkg::PSC_LIM_256
                                                       : fcct_pkg::PSC_LIM_16;
    assign edge_i    = ctrl_q[i][fcct_pkg::BIT_RISING] ? (trig_bus.level[i] && !lvl_p_q[i])
                                                       : (!trig_bus.level[i] && lvl_p_q[i]);
    assign slope_chg = ctl_wr && !data_in[fcct_pkg::BIT_SWRST]
                       && (data_in[fcct_pkg::BIT_RISING] != ctrl_q[i][fcct_pkg::BIT_RISING]);
    assign trig_ev   = edge_i || slope_chg;
    assign tick      = timer && (psc_q[i] == psc_lim);
    assign dec       = (st_q[i] == fcct_pkg::FCCT_RUN) && (timer ? tick : trig_ev);
    assign zero_ev[i] = dec && (cnt_q[i] == 8'h01);

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        lvl_p_q[i] <= 1'b0;
      else
        lvl_p_q[i] <= trig_bus.level[i];
    end

    // Control and time-constant registers.
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        ctrl_q[i] <= fcct_pkg::CTRL_RST;
        tc_q[i]   <= fcct_pkg::TC_RST;
        tcf_q[i]  <= 1'b0;
      end
      else if (tc_wr)
      begin
        tc_q[i]  <= data_in;
        tcf_q[i] <= 1'b0;
      end
      else if (ctl_wr)
      begin
        ctrl_q[i] <= data_in;
        tcf_q[i]  <= data_in[fcct_pkg::BIT_TCF];
      end
    end

    // Channel sequencing.
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        st_q[i]  <= fcct_pkg::FCCT_IDLE;
        dly_q[i] <= 2'h0;
      end
      else if (ctl_wr && data_in[fcct_pkg::BIT_SWRST])
        st_q[i] <= fcct_pkg::FCCT_IDLE;
      else if (tc_wr && st_q[i] != fcct_pkg::FCCT_RUN)
      begin
        dly_q[i] <= 2'h0;
        if (!timer)
          st_q[i] <= fcct_pkg::FCCT_RUN;
        else if (ctrl_q[i][fcct_pkg::BIT_EXTTRIG])
          st_q[i] <= fcct_pkg::FCCT_ARMED;
        else
          st_q[i] <= fcct_pkg::FCCT_DELAY;
      end
      else
      begin
        case (st_q[i])
          fcct_pkg::FCCT_DELAY:
          begin
            dly_q[i] <= dly_q[i] + 2'h1;
            if (dly_q[i] == fcct_pkg::START_DELAY_CYC - 2'h1)
              st_q[i] <= fcct_pkg::FCCT_RUN;
          end
          fcct_pkg::FCCT_ARMED:
          begin
            if (trig_ev)
              st_q[i] <= fcct_pkg::FCCT_RUN;
          end
          fcct_pkg::FCCT_IDLE,
          fcct_pkg::FCCT_RUN:
            st_q[i] <= st_q[i];
          default:
            st_q[i] <= fcct_pkg::FCCT_IDLE;
        endcase
      end
    end

    // Prescaler restarts whenever the timer is not yet running.
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        psc_q[i] <= 8'h00;
      else if (st_q[i] != fcct_pkg::FCCT_RUN || tick)
        psc_q[i] <= 8'h00;
      else
        psc_q[i] <= psc_q[i] + 8'h01;
    end

    // Down-counter; a value of zero counts as 256 by wrapping.
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        cnt_q[i] <= 8'h00;
      else if (tc_wr && st_q[i] != fcct_pkg::FCCT_RUN)
        cnt_q[i] <= data_in;
      else if (zero_ev[i])
        cnt_q[i] <= tc_q[i];
      else if (dec)
        cnt_q[i] <= cnt_q[i] - 8'h01;
    end

    // Pending request: a new zero count wins over the acknowledge clear.
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        pend_q[i] <= 1'b0;
      else if (!ctrl_q[i][fcct_pkg::BIT_IE])
        pend_q[i] <= 1'b0;
      else if (zero_ev[i])
        pend_q[i] <= 1'b1;
      else if (grant && win == 2'(i))
        pend_q[i] <= 1'b0;
    end

    // In-service marker set by acknowledge, cleared by the return opcode pair.
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        srv_q[i] <= 1'b0;
      else if (grant && win == 2'(i))
        srv_q[i] <= 1'b1;
      else if (release_stb && rel == 2'(i))
        srv_q[i] <= 1'b0;
    end

    if (i < 3)
    begin : g_zc
      logic zc_q;

      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          zc_q <= 1'b0;
        else
          zc_q <= zero_ev[i];
      end

      assign zero_count_pulse[i] = zc_q;
    end
  end

  // Winner is the lowest pending channel with nothing at or above it in service.
  always_comb
  begin
    logic blk;
    blk   = 1'b0;
    win_v = 1'b0;
    win   = 2'h0;
    for (int i = 0; i < NCH; i++)
    begin
      blk = blk | srv_q[i];
      if (!blk && pend_q[i] && !win_v)
      begin
        win_v = 1'b1;
        win   = 2'(i);
      end
    end
  end

  // The channel released by a return is the highest-priority one in service.
  always_comb
  begin
    rel_v   = 1'b0;
    rel     = 2'h0;
    any_srv = 1'b0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (srv_q[i])
      begin
        rel_v = 1'b1;
        rel   = 2'(i);
      end
      any_srv = any_srv | srv_q[i];
    end
  end

  assign grant        = ack_stb && priority_in && win_v;
  assign priority_out = priority_in && !any_srv;

  // Return-opcode watcher on completed opcode fetches.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      op_q <= 8'h00;
    else if (fetch_cond)
      op_q <= data_in;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      after_ed_q <= 1'b0;
    else if (fetch_end)
      after_ed_q <= (op_q == fcct_pkg::RETURN_OP_FIRST);
  end

  assign release_stb = fetch_end && after_ed_q && (op_q == fcct_pkg::RETURN_OP_SECOND)
                       && priority_in && rel_v;

  // Interrupt request held low while an allowed enabled channel is pending.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      int_q <= 1'b0;
    else
      int_q <= win_v && priority_in;
  end

  assign int_req_out  = 1'b0;
  assign int_req_oe_n = !int_q;

  // Data bus: vector during acknowledge, else the selected down-counter.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ack_drive_q <= 1'b0;
    else if (!ack_cond)
      ack_drive_q <= 1'b0;
    else if (grant)
      ack_drive_q <= 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      data_q <= 8'h00;
    else if (grant)
      data_q <= {vec_q, win, 1'b0};
    else if (!ack_drive_q)
      data_q <= cnt_q[channel_select];
  end

  assign data_out  = data_q;
  assign data_oe_n = !(nrst && (rd_cond || (ack_cond && ack_drive_q)));

endmodule : fcct_top

/* verif/fcct_checker.sv */
// Checker for the counter/timer top: bus decode, daisy chain and pin relations.
// Assumes it is bound to fcct_top and sees only that module's ports.
`timescale 1ns/1ps

module fcct_checker (
  // Clock and reset
  input logic       clk,
  input logic       nrst,
  // CPU bus
  input logic       chip_enable_n,
  input logic       io_request_n,
  input logic       read_n,
  input logic       opcode_fetch_cycle_n,
  input logic [7:0] data_out,
  input logic       data_oe_n,
  // Daisy chain, interrupt and channel pins
  input logic       priority_in,
  input logic       priority_out,
  input logic       int_req_out,
  input logic       int_req_oe_n,
  input logic [2:0] zero_count_pulse
);
  logic rd_dec;
  logic wr_dec;
  logic ack_dec;

  assign rd_dec  = !io_request_n && !chip_enable_n && !read_n && opcode_fetch_cycle_n;
  assign wr_dec  = !io_request_n && !chip_enable_n && read_n && opcode_fetch_cycle_n;
  assign ack_dec = !io_request_n && !opcode_fetch_cycle_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_chain_gate: assert property (priority_out |-> priority_in)
    else $error("priority out high without priority in");
  a_service_blocks: assert property (ack_dec && !data_oe_n |-> !priority_out)
    else $error("priority out high during vector drive");
  a_read_drives: assert property (rd_dec |-> !data_oe_n)
    else $error("read cycle left the bus undriven");
  a_write_floats: assert property (wr_dec |-> data_oe_n)
    else $error("bus driven in a write cycle");
  a_fetch_floats: assert property (io_request_n |-> data_oe_n)
    else $error("bus driven without an I/O request");
  a_vector_lsb: assert property (ack_dec && !data_oe_n |-> !data_out[0])
    else $error("vector bit 0 set");
  a_ack_refused: assert property ($rose(ack_dec) && !priority_in |=> data_oe_n)
    else $error("vector driven without priority");
  a_zc_single: assert property (|zero_count_pulse |=>
    (zero_count_pulse & $past(zero_count_pulse)) == 3'h0)
    else $error("zero count pulse longer than one cycle");
  a_odrain_low: assert property (!int_req_oe_n |-> int_req_out == 1'b0 && $past(priority_in))
    else $error("interrupt pin drives high");

  c_ack_vector: cover property (ack_dec && !data_oe_n);
  c_zero_count: cover property (|zero_count_pulse);
  c_read_hold: cover property (rd_dec ##1 rd_dec);
endmodule : fcct_checker

bind fcct_top fcct_checker i_fcct_checker (.clk, .nrst, .chip_enable_n, .io_request_n,
  .read_n, .opcode_fetch_cycle_n, .data_out, .data_oe_n, .priority_in, .priority_out,
  .int_req_out, .int_req_oe_n, .zero_count_pulse);

/* verif/fcct_cpu_model.sv */
// CPU bus model: write, read, acknowledge and opcode fetch cycles.
// Assumes the bench calls its tasks; all signals change on the falling edge.
`timescale 1ns/1ps

module fcct_cpu_model (
  input  logic       clk,
  output logic       chip_enable_n,
  output logic       io_request_n,
  output logic       read_n,
  output logic       opcode_fetch_cycle_n,
  output logic [1:0] channel_select,
  output logic [7:0] data_in,
  input  logic [7:0] data_out,
  input  logic       data_oe_n
);
  initial
  begin
    {chip_enable_n, io_request_n, read_n, opcode_fetch_cycle_n} = 4'hF;
    channel_select = 2'h0;
    data_in = 8'h00;
  end

  // Strobes are {chip_enable_n, io_request_n, read_n, opcode_fetch_cycle_n}.
  // The answer is taken while the request still stands; a released bus shows
  // the inverse of the last word so that stale data never looks valid.
  task automatic cyc(input logic [3:0] c, input logic [1:0] s, input logic [7:0] d,
                     input int n, output logic [8:0] q);
    @(negedge clk);
    {chip_enable_n, io_request_n, read_n, opcode_fetch_cycle_n} = c;
    channel_select = s;
    data_in = d;
    repeat (n) @(posedge clk);
    @(negedge clk);
    q = {data_oe_n, data_out};
    {chip_enable_n, io_request_n, read_n, opcode_fetch_cycle_n} = 4'hF;
    data_in = ~d;
  endtask : cyc
endmodule : fcct_cpu_model

/* verif/testbench.sv */
// Self-checking bench for the four-channel counter/timer.
// Assumes fcct_top, its checker and the CPU bus model are compiled before it.
`timescale 1ns/1ps

module testbench;
  logic       clk;
  logic       nrst;
  logic       priority_in;
  logic       chip_enable_n;
  logic       io_request_n;
  logic       read_n;
  logic       opcode_fetch_cycle_n;
  logic [1:0] channel_select;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe_n;
  logic       priority_out;
  logic       int_req_out;
  logic       int_req_oe_n;
  logic [3:0] ext_clock_trigger;
  logic [2:0] zero_count_pulse;
  logic [8:0] q;
  int         miscompares;
  int         samples_checked;

  fcct_top i_fcct_top (.clk, .nrst, .chip_enable_n, .io_request_n, .read_n,
    .opcode_fetch_cycle_n, .channel_select, .data_in, .data_out, .data_oe_n, .priority_in,
    .priority_out, .int_req_out, .int_req_oe_n, .ext_clock_trigger, .zero_count_pulse);
  fcct_cpu_model i_fcct_cpu_model (.clk, .chip_enable_n, .io_request_n, .read_n,
    .opcode_fetch_cycle_n, .channel_select, .data_in, .data_out, .data_oe_n);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    i_fcct_cpu_model.cyc(4'h3, s, d, 1, q);
  endtask : wr

  // Cycles from one zero-count pulse of a channel to the next.
  task automatic gap(input int ch, input int exp);
    int n;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do begin @(negedge clk); n++; end while (zero_count_pulse[ch] !== 1'b1 && n < 9000);
    end
    chk(16'(n), 16'(exp), "zero count interval");
  endtask : gap

  // One trigger pulse, 6 cycles high then 6 low; reports a zero-count pulse seen.
  task automatic trig(input int ch, output logic seen);
    seen = 1'b0;
    for (int k = 0; k < 12; k++)
    begin
      @(negedge clk);
      ext_clock_trigger[ch] = (k < 6);
      if (ch < 3 && zero_count_pulse[ch] === 1'b1)
        seen = 1'b1;
    end
  endtask : trig

  task automatic t_timer;
    wr(2'h0, 8'h87);
    wr(2'h0, 8'h02);
    wr(2'h0, 8'hAE);
    gap(0, 32);
    chk(int_req_oe_n, 1'b0, "interrupt not raised");
    i_fcct_cpu_model.cyc(4'hA, 2'h0, 8'h00, 2, q);
    chk(q, 9'h0A8, "channel 0 vector");
    chk(priority_out, 1'b0, "chain open in service");
    i_fcct_cpu_model.cyc(4'hC, 2'h0, 8'hED, 2, q);
    i_fcct_cpu_model.cyc(4'hC, 2'h0, 8'h4D, 2, q);
    @(negedge clk);
    chk(priority_out, 1'b1, "chain not released");
    i_fcct_cpu_model.cyc(4'h1, 2'h0, 8'h00, 2, q);
    chk(q[8] == 1'b0 && (q[7:0] == 8'h01 || q[7:0] == 8'h02), 1'b1, "count read");
    gap(0, 32);
    wr(2'h0, 8'h03);
    repeat (2) @(negedge clk);
    for (int k = 0; k < 100; k++)
      @(negedge clk) chk({int_req_oe_n, zero_count_pulse[0]}, 2'h2, "stopped");
    $display("timer test done");
  endtask : t_timer

  task automatic t_counter;
    logic s;
    wr(2'h1, 8'h55);
    wr(2'h1, 8'h03);
    trig(1, s);
    i_fcct_cpu_model.cyc(4'h1, 2'h1, 8'h00, 2, q);
    chk(q, 9'h002, "count after one edge");
    trig(1, s);
    chk(s, 1'b0, "early zero count");
    trig(1, s);
    chk(s, 1'b1, "zero count missing");
    wr(2'h1, 8'h41);
    repeat (6) @(negedge clk);
    i_fcct_cpu_model.cyc(4'h1, 2'h1, 8'h00, 2, q);
    chk(q, 9'h002, "slope change edge");
    wr(2'h1, 8'h45);
    wr(2'h1, 8'h05);
    trig(1, s);
    trig(1, s);
    i_fcct_cpu_model.cyc(4'h1, 2'h1, 8'h00, 2, q);
    chk(q, 9'h005, "new constant at zero");
    $display("counter test done");
  endtask : t_counter

  task automatic t_chan3;
    logic s;
    wr(2'h3, 8'hC5);
    wr(2'h3, 8'h01);
    trig(3, s);
    repeat (4) @(negedge clk);
    chk(int_req_oe_n, 1'b0, "channel 3 request");
    priority_in = 1'b0;
    i_fcct_cpu_model.cyc(4'hA, 2'h0, 8'h00, 2, q);
    chk(q[8], 1'b1, "vector without priority");
    priority_in = 1'b1;
    i_fcct_cpu_model.cyc(4'hA, 2'h0, 8'h00, 2, q);
    chk(q, 9'h0AE, "channel 3 vector");
    $display("channel 3 test done");
  endtask : t_chan3

  task automatic t_timer2;
    logic s;
    wr(2'h2, 8'h27);
    wr(2'h2, 8'h01);
    gap(2, 256);
    wr(2'h2, 8'h0F);
    wr(2'h2, 8'h00);
    repeat (40) @(negedge clk) chk(zero_count_pulse[2], 1'b0, "ran before trigger");
    trig(2, s);
    gap(2, 4096);
    $display("timer2 test done");
  endtask : t_timer2

  initial
  begin
    #(8 * 40000);
    miscompares++;
    stop_test();
  end

  initial
  begin
    nrst = 1'b0;
    priority_in = 1'b1;
    ext_clock_trigger = 4'h0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({data_oe_n, int_req_oe_n, zero_count_pulse, priority_out, data_out}, 14'h3100, "reset");
    $display("reset test done");
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    t_timer();
    t_counter();
    t_chan3();
    t_timer2();
    stop_test();
  end
endmodule : testbench
